/* File: enc_regs.svh */
// Register offsets, field positions, reset values and timing constants
`ifndef ENC_REGS_SVH
`define ENC_REGS_SVH

// Byte offsets of the register words
`define CTRL_OFS 8'h00
`define THR_OFS 8'h04
`define HYST_OFS 8'h08
`define RANGE_OFS 8'h0c
`define STAT_OFS 8'h10
`define COUNT_OFS 8'h14
`define RESULT_OFS 8'h18

// Control word fields
`define CTRL_START 0
`define CTRL_DUAL 1
`define CTRL_IDXGATE 2
`define CTRL_FILT_LSB 4
`define CTRL_FILT_MSB 5

// Status word fields
`define STAT_RUN 0
`define STAT_ARMED 1
`define STAT_DIR 2
`define STAT_LVL_A 3
`define STAT_LVL_B 4
`define STAT_LVL_I 5
`define STAT_IDX_SEEN 6

// Reset values and the full-scale result
`define CTRL_RST 32'h00000000
`define THR_RST 16'h0000
`define HYST_RST 16'h0100
`define RANGE_RST 16'h7fff
`define FULL_SCALE 32'sh00007fff

// Clock rate and filter corners
`define SYS_CLK_HZ 25000000
`define FC_20K_HZ 20000
`define FC_2K_HZ 2000
`define FC_200_HZ 200

`endif

/* File: enc_pkg.sv */
// Types shared by the encoder input front end
package enc_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ARMED = 3'b010,
      ST_RUN = 3'b100
   } gate_state_t;

   typedef enum logic [1:0] {
      FILT_NONE = 2'b00,
      FILT_20K = 2'b01,
      FILT_2K = 2'b10,
      FILT_200 = 2'b11
   } filt_sel_t;

   typedef struct packed {
      logic signed [15:0] trk_a;
      logic signed [15:0] trk_b;
      logic signed [15:0] idx;
   } sample_set_t;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
   } ahb_req_t;

   typedef struct packed {
      sample_set_t smp1;
      sample_set_t smp2;
      logic signed [31:0] acc_a;
      logic signed [31:0] acc_b;
      logic signed [31:0] acc_i;
      logic lvl_a;
      logic lvl_b;
      logic lvl_i;
      gate_state_t gate;
      logic start_d;
      logic idx_seen;
      logic signed [15:0] count;
      logic dir;
      logic start;
      logic dual;
      logic idx_gate;
      filt_sel_t filt;
      logic signed [15:0] thr;
      logic [15:0] hyst;
      logic [15:0] range;
      logic signed [15:0] result;
      logic ph_valid;
      logic ph_write;
      logic [7:0] ph_addr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } enc_state_t;

endpackage : enc_pkg

/* File: enc_input_front.sv */
// Encoder channel front end: filter, comparator, decoder, index gate
`timescale 1ns/1ps
`include "enc_regs.svh"

////////////////////////////////////////////////////////////////////////
module enc_input_front #(
   parameter int SMP_W = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire enc_pkg::ahb_req_t ahb_req,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Conditioned sensor samples
   input wire enc_pkg::sample_set_t smp_in,
   // Position outputs
   output logic signed [15:0] pos_count,
   output logic signed [15:0] pos_result,
   output logic pos_dir,
   output logic pos_running
);

   ////////////////////////////////////////////////////////////////////
   // Derived constants

   localparam int SH_20K = $clog2(`SYS_CLK_HZ / (6 * `FC_20K_HZ));
   localparam int SH_2K = $clog2(`SYS_CLK_HZ / (6 * `FC_2K_HZ));
   localparam int SH_200 = $clog2(`SYS_CLK_HZ / (6 * `FC_200_HZ));

   // Carrier packs each sample at a fixed 16 bits
   if (SMP_W != 16) begin : g_bad_width
      $error("enc_input_front: sample width must be 16");
   end

   // A shift past the accumulator would freeze the filters
   if (SH_200 > 31 || SH_20K < 1) begin : g_bad_clock
      $error("enc_input_front: clock rate does not suit the filters");
   end

   ////////////////////////////////////////////////////////////////////
   // Functions

   // First-order low-pass, acc holds the output shifted up by 16
   function automatic logic signed [31:0] lp_step(
      input logic signed [31:0] acc,
      input logic signed [15:0] x,
      input enc_pkg::filt_sel_t sel
   );
      logic signed [32:0] diff;
      logic signed [32:0] stepv;
      diff = 33'(signed'({x, 16'h0000})) - 33'(acc);
      stepv = 33'sh0;
      case (sel)
         enc_pkg::FILT_20K: stepv = diff >>> SH_20K;
         enc_pkg::FILT_2K: stepv = diff >>> SH_2K;
         enc_pkg::FILT_200: stepv = diff >>> SH_200;
         default: stepv = 33'sh0;
      endcase
      // Bypass loads the sample whole, no settling time
      if (sel == enc_pkg::FILT_NONE) begin
         lp_step = {x, 16'h0000};
      end else begin
         lp_step = 32'(33'(acc) + stepv);
      end
   endfunction : lp_step

   // Comparator with hysteresis band around the threshold
   function automatic logic cmp_hyst(
      input logic lvl,
      input logic signed [31:0] acc,
      input logic signed [15:0] thr,
      input logic [15:0] hyst
   );
      logic signed [17:0] y;
      logic signed [17:0] half;
      logic signed [17:0] hi;
      logic signed [17:0] lo;
      // Part-select is unsigned; cast back or negatives look huge
      y = 18'(signed'(acc[31:16]));
      half = 18'(signed'({1'b0, hyst[15:1]}));
      hi = 18'(thr) + half;
      lo = 18'(thr) - half;
      cmp_hyst = lvl;
      if (!lvl && y > hi) begin
         cmp_hyst = 1'b1;
      end else if (lvl && y < lo) begin
         cmp_hyst = 1'b0;
      end
   endfunction : cmp_hyst

   // Quadrature step from previous and new {a,b}
   function automatic logic signed [1:0] quad_step(
      input logic [1:0] prev,
      input logic [1:0] cur
   );
      case ({prev, cur})
         4'b00_10, 4'b10_11, 4'b11_01, 4'b01_00: quad_step = 2'sb01;
         4'b00_01, 4'b01_11, 4'b11_10, 4'b10_00: quad_step = -2'sb01;
         // Both tracks moved at once: direction unknown, dropped
         default: quad_step = 2'sb00;
      endcase
   endfunction : quad_step

   // Count scaled so the range maximum reaches full scale
   function automatic logic signed [15:0] scale(
      input logic signed [15:0] cnt,
      input logic [15:0] range
   );
      logic signed [31:0] num;
      logic signed [31:0] den;
      logic signed [31:0] q;
      num = 32'(cnt) * `FULL_SCALE;
      // Zero range would divide by zero; treated as one
      den = (range == 16'h0000) ? 32'sh1 : 32'(signed'({1'b0, range}));
      q = num / den;
      if (q > `FULL_SCALE) begin
         scale = 16'sh7fff;
      end else if (q < -`FULL_SCALE) begin
         scale = -16'sh7fff;
      end else begin
         scale = q[15:0];
      end
   endfunction : scale

   // Read mux for the register words
   function automatic logic [31:0] rd_word(
      input logic [7:0] addr,
      input enc_pkg::enc_state_t s
   );
      rd_word = 32'h00000000;
      case (addr)
         `CTRL_OFS: begin
            rd_word[`CTRL_START] = s.start;
            rd_word[`CTRL_DUAL] = s.dual;
            rd_word[`CTRL_IDXGATE] = s.idx_gate;
            rd_word[`CTRL_FILT_MSB:`CTRL_FILT_LSB] = s.filt;
         end
         `THR_OFS: rd_word[15:0] = s.thr;
         `HYST_OFS: rd_word[15:0] = s.hyst;
         `RANGE_OFS: rd_word[15:0] = s.range;
         `STAT_OFS: begin
            rd_word[`STAT_RUN] = (s.gate == enc_pkg::ST_RUN);
            rd_word[`STAT_ARMED] = (s.gate == enc_pkg::ST_ARMED);
            rd_word[`STAT_DIR] = s.dir;
            rd_word[`STAT_LVL_A] = s.lvl_a;
            rd_word[`STAT_LVL_B] = s.lvl_b;
            rd_word[`STAT_LVL_I] = s.lvl_i;
            rd_word[`STAT_IDX_SEEN] = s.idx_seen;
         end
         `COUNT_OFS: rd_word[15:0] = s.count;
         `RESULT_OFS: rd_word[15:0] = s.result;
         default: rd_word = 32'h00000000;
      endcase
   endfunction : rd_word

   ////////////////////////////////////////////////////////////////////
   // State

   enc_pkg::enc_state_t st_reg;
   enc_pkg::enc_state_t st_next;

   always_comb begin
      logic accept;
      logic na;
      logic nb;
      logic ni;
      logic start_rise;
      logic idx_rise;
      logic signed [1:0] qs;
      logic signed [15:0] cnt;
      st_next = st_reg;
      accept = 1'b0;
      na = 1'b0;
      nb = 1'b0;
      ni = 1'b0;
      start_rise = 1'b0;
      idx_rise = 1'b0;
      qs = 2'sb00;
      cnt = st_reg.count;

      // Two stages before the filters; first stage feeds only
      // the second
      st_next.smp1 = smp_in;
      st_next.smp2 = st_reg.smp1;

      // Smoothing filters
      st_next.acc_a = lp_step(st_reg.acc_a, st_reg.smp2.trk_a,
         st_reg.filt);
      st_next.acc_b = lp_step(st_reg.acc_b, st_reg.smp2.trk_b,
         st_reg.filt);
      // Index always at 20 kHz whatever the track setting
      st_next.acc_i = lp_step(st_reg.acc_i, st_reg.smp2.idx,
         enc_pkg::FILT_20K);

      // Detectors; index shares the threshold and hysteresis
      // used by both tracks
      na = cmp_hyst(st_reg.lvl_a, st_reg.acc_a, st_reg.thr,
         st_reg.hyst);
      nb = cmp_hyst(st_reg.lvl_b, st_reg.acc_b, st_reg.thr,
         st_reg.hyst);
      ni = cmp_hyst(st_reg.lvl_i, st_reg.acc_i, st_reg.thr,
         st_reg.hyst);
      st_next.lvl_a = na;
      st_next.lvl_b = nb;
      st_next.lvl_i = ni;
      idx_rise = ni & ~st_reg.lvl_i;

      // Measurement gate
      st_next.start_d = st_reg.start;
      start_rise = st_reg.start & ~st_reg.start_d;
      case (st_reg.gate)
         enc_pkg::ST_IDLE: begin
            if (start_rise) begin
               cnt = 16'sh0000;
               st_next.idx_seen = 1'b0;
               if (st_reg.idx_gate) begin
                  st_next.gate = enc_pkg::ST_ARMED;
               end else begin
                  st_next.gate = enc_pkg::ST_RUN;
               end
            end
         end
         enc_pkg::ST_ARMED: begin
            cnt = 16'sh0000;
            if (!st_reg.start) begin
               st_next.gate = enc_pkg::ST_IDLE;
            end else if (idx_rise) begin
               st_next.idx_seen = 1'b1;
               st_next.gate = enc_pkg::ST_RUN;
            end
         end
         enc_pkg::ST_RUN: begin
            if (!st_reg.start) begin
               st_next.gate = enc_pkg::ST_IDLE;
            end else if (st_reg.dual) begin
               // Every edge of both tracks, four counts per line
               qs = quad_step({st_reg.lvl_a, st_reg.lvl_b},
                  {na, nb});
               cnt = st_reg.count + 16'(qs);
               if (qs == 2'sb01) begin
                  st_next.dir = 1'b0;
               end else if (qs == -2'sb01) begin
                  st_next.dir = 1'b1;
               end
            end else begin
               st_next.dir = 1'b0;
               if (na & ~st_reg.lvl_a) begin
                  cnt = st_reg.count + 16'sh0001;
               end
            end
         end
         default: st_next.gate = enc_pkg::ST_IDLE;
      endcase
      // Plain two's complement wrap, no saturation
      st_next.count = cnt;
      st_next.result = scale(cnt, st_reg.range);

      // Bus data phase: write lands one cycle after its address
      if (st_reg.ph_valid && st_reg.ph_write) begin
         case (st_reg.ph_addr)
            `CTRL_OFS: begin
               st_next.start = hwdata[`CTRL_START];
               st_next.dual = hwdata[`CTRL_DUAL];
               st_next.idx_gate = hwdata[`CTRL_IDXGATE];
               st_next.filt = enc_pkg::filt_sel_t'(
                  hwdata[`CTRL_FILT_MSB:`CTRL_FILT_LSB]);
               // No stale direction once single-track is chosen
               if (!hwdata[`CTRL_DUAL]) begin
                  st_next.dir = 1'b0;
               end
            end
            `THR_OFS: st_next.thr = hwdata[15:0];
            `HYST_OFS: st_next.hyst = hwdata[15:0];
            `RANGE_OFS: st_next.range = hwdata[15:0];
            default: st_next.thr = st_reg.thr;
         endcase
      end

      // Bus address phase: zero wait states, reads answered next cycle
      // Read data comes from the current registers, so a read in the
      // data phase of a write to the same word returns the old value
      accept = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
      st_next.ph_valid = accept;
      st_next.ph_write = accept & ahb_req.hwrite;
      st_next.ph_addr = ahb_req.haddr[7:0];
      if (accept && !ahb_req.hwrite) begin
         st_next.hrdata = rd_word(ahb_req.haddr[7:0], st_reg);
      end
      st_next.hreadyout = 1'b1;
      st_next.hresp = 1'b0;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_reg <= '0;
         st_reg.gate <= enc_pkg::ST_IDLE;
         st_reg.filt <= enc_pkg::FILT_NONE;
         // Gating off so counting never waits after reset
         st_reg.idx_gate <= 1'(`CTRL_RST >> `CTRL_IDXGATE);
         st_reg.thr <= `THR_RST;
         st_reg.hyst <= `HYST_RST;
         st_reg.range <= `RANGE_RST;
         st_reg.hreadyout <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs

   assign hrdata = st_reg.hrdata;
   assign hreadyout = st_reg.hreadyout;
   assign hresp = st_reg.hresp;
   assign pos_count = st_reg.count;
   assign pos_result = st_reg.result;
   assign pos_dir = st_reg.dir;
   // One-hot state, so the run bit itself is the flop
   assign pos_running = st_reg.gate[2];

endmodule : enc_input_front

/* File: encoder_model.sv */
// Behavioural quadrature encoder with index track
`timescale 1ns/1ps
module encoder_model (
   // Clock
   input wire logic sys_clk,
   // Motion commands
   input wire logic step,
   input wire logic back,
   input wire logic jump,
   input wire logic idx_on,
   // Analog levels of the tracks
   input wire logic signed [15:0] hi,
   input wire logic signed [15:0] lo,
   // Samples to the front end
   output enc_pkg::sample_set_t smp
);
   logic [1:0] ph_reg = 2'h0;
   // Jump moves two phases at once: an illegal double change
   always_ff @(posedge sys_clk) begin
      if (jump) begin
         ph_reg <= ph_reg + 2'h2;
      end else if (step) begin
         ph_reg <= back ? ph_reg - 2'h1 : ph_reg + 2'h1;
      end
   end
   // Gray order 00,10,11,01 keeps B a quarter period behind A
   assign smp = '{(ph_reg == 2'h1 || ph_reg == 2'h2) ? hi : lo,
      ph_reg[1] ? hi : lo, idx_on ? hi : lo};
endmodule : encoder_model

/* File: enc_input_front_sva.sv */
// Port checker for the encoder input front end
`timescale 1ns/1ps
`include "enc_regs.svh"
module enc_input_front_sva (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Register bus
   input wire enc_pkg::ahb_req_t ahb_req,
   input wire logic [31:0] hwdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Position outputs
   input wire logic signed [15:0] pos_count,
   input wire logic signed [15:0] pos_result,
   input wire logic pos_dir,
   input wire logic pos_running
);
   logic wr_reg, ctrl_wr, go_plain, go_gated;
   logic [7:0] wa_reg;
   logic [2:0] ctrl_reg;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Mirror of the low three control bits (start, dual, index gate), rebuilt from bus writes
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_reg <= 1'b0;
         ctrl_reg <= 3'h0;
      end else begin
         wr_reg <= ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hwrite
            && ahb_req.hready;
         if (ctrl_wr) begin
            ctrl_reg <= hwdata[2:0];
         end
      end
      wa_reg <= ahb_req.haddr[7:0];
   end
   assign ctrl_wr = wr_reg && wa_reg == `CTRL_OFS;
   assign go_plain = ctrl_wr && hwdata[0] && !hwdata[2] && !ctrl_reg[0];
   assign go_gated = ctrl_wr && hwdata[0] && hwdata[2] && !ctrl_reg[0];
////////////////////////////////////////
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not okay");
   a_reset_clears: assert property (
      disable iff (1'b0) rst |=> pos_count == 16'sh0000
      && pos_result == 16'sh0000 && !pos_dir && !pos_running)
      else $error("outputs not cleared");
   a_count_step: assert property (
      $past(pos_running) |-> pos_count == $past(pos_count)
      || pos_count == $past(pos_count) + 16'sh0001
      || pos_count == $past(pos_count) - 16'sh0001)
      else $error("count jumped");
   a_idle_hold: assert property (
      !pos_running |=> pos_count == $past(pos_count)
      || pos_count == 16'sh0000)
      else $error("count moved while idle");
   a_single_nodir: assert property (!ctrl_reg[1] |-> !pos_dir)
      else $error("direction in single-track mode");
   a_down_dir: assert property (
      $past(pos_running) && ctrl_reg[1]
      && pos_count == $past(pos_count) - 16'sh0001 |-> ##[0:1] pos_dir)
      else $error("backward step not negative");
   a_start_runs: assert property (
      go_plain |-> ##[1:3] pos_running)
      else $error("start did not run");
   a_gate_waits: assert property (
      go_gated |=> !pos_running [*3])
      else $error("gated start ran at once");
   c_gated: cover property (go_gated ##[1:500] pos_running);
   c_back: cover property (pos_dir && pos_running);
   c_scaled: cover property (pos_running && pos_result != pos_count);
endmodule : enc_input_front_sva
bind enc_input_front enc_input_front_sva sva_u (.sys_clk(sys_clk),
   .rst(rst), .ahb_req(ahb_req), .hwdata(hwdata), .hreadyout(hreadyout),
   .hresp(hresp), .pos_count(pos_count), .pos_result(pos_result),
   .pos_dir(pos_dir), .pos_running(pos_running));

/* File: encoder_input_conditioning_tb_top.sv */
// Self-checking bench for the encoder input front end
`timescale 1ns/1ps
`include "enc_regs.svh"
module encoder_input_conditioning_tb_top;
   logic sys_clk = 1'b0, rst = 1'b1, hwrite = 1'b0;
   logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hrdata, q;
   logic hreadyout, hresp, pos_dir, pos_running;
   logic step = 1'b0, back = 1'b0, jump = 1'b0, idx_on = 1'b0;
   logic signed [15:0] hi = 16'sh0200, lo = 16'sh0000;
   logic signed [15:0] pos_count, pos_result;
   enc_pkg::ahb_req_t req;
   enc_pkg::sample_set_t smp;
   int errors = 0, cmp_count = 0, t, tp, n;
   always #20 sys_clk = ~sys_clk;
   assign req = '{1'b1, haddr, htrans, hwrite, 3'h2, hreadyout};
   encoder_model enc_u (.sys_clk(sys_clk), .step(step), .back(back),
      .jump(jump), .idx_on(idx_on), .hi(hi), .lo(lo), .smp(smp));
   enc_input_front dut_u (.sys_clk(sys_clk), .rst(rst), .ahb_req(req),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .smp_in(smp), .pos_count(pos_count),
      .pos_result(pos_result), .pos_dir(pos_dir),
      .pos_running(pos_running));
////////////////////////////////////////
   task automatic summarize();
      if (errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s: expected %h, seen %h", nm, e, g);
      end
   endtask : chk
   // One single transfer; a stuck bus ends the run
   task automatic bus(input logic [7:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] r);
      int k;
      k = 0;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do begin
         @(posedge sys_clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge sys_clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 99);
      r = hrdata;
      if (k >= 99) begin errors++; summarize(); end
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask : wr
   task automatic rdc(input string nm, input logic [7:0] a,
      input logic [15:0] e);
      logic [31:0] r;
      bus(a, 1'b0, 32'h00000000, r);
      chk(nm, e, r[15:0]);
   endtask : rdc
   // Eight idle cycles let each phase pass the input pipeline
   task automatic move(input int k, input logic b);
      repeat (k) begin
         step <= 1'b1;
         back <= b;
         @(posedge sys_clk);
         step <= 1'b0;
         repeat (8) @(posedge sys_clk);
      end
   endtask : move
   task automatic waitc(input logic [15:0] e, input int lim);
      for (t = 0; pos_count !== e && t < lim; t++) @(posedge sys_clk);
      chk("count", e, pos_count);
      if (pos_count !== e) summarize();
   endtask : waitc
////////////////////////////////////////
   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rdc("ctrl", `CTRL_OFS, 16'h0000);
      rdc("range", `RANGE_OFS, 16'h7fff);
      rdc("spare", 8'h40, 16'h0000);
      wr(`THR_OFS, 32'h00000100);
      wr(`HYST_OFS, 32'h00000200);
      wr(`CTRL_OFS, 32'h00000001);
      move(1, 1'b0);
      chk("count", 16'h0000, pos_count);
      hi <= 16'sh0201;
      waitc(16'h0001, 20);
      move(4, 1'b0);
      chk("count", 16'h0001, pos_count);
      lo <= 16'shffff;
      move(4, 1'b0);
      waitc(16'h0002, 20);
      hi <= 16'sh4000;
      lo <= 16'shc000;
      move(8, 1'b1);
      waitc(16'h0004, 20);
      chk("dir", 16'h0000, {15'h0000, pos_dir});
      // Each slower corner must take longer to pass one edge
      for (int f = 0; f < 4; f++) begin
         wr(`CTRL_OFS, {26'h0000000, f[1:0], 4'h0});
         move(2, 1'b0);
         q = 32'hffffffff;
         for (n = 0; q[`STAT_LVL_A] !== 1'b0 && n < 30000; n++) begin
            bus(`STAT_OFS, 1'b0, 32'h00000000, q);
         end
         chk("level", 16'h0000, {15'h0000, q[`STAT_LVL_A]});
         wr(`CTRL_OFS, {26'h0000000, f[1:0], 4'h1});
         move(2, 1'b0);
         waitc(16'h0001, 60000);
         if (f > 0) chk("delay", 16'h0001, {15'h0000, t > tp});
         tp = t;
      end
      wr(`CTRL_OFS, 32'h00000000);
      wr(`RANGE_OFS, 32'h00000008);
      wr(`CTRL_OFS, 32'h00000003);
      move(6, 1'b0);
      waitc(16'h0006, 20);
      chk("dir", 16'h0000, {15'h0000, pos_dir});
      chk("result", 16'h5fff, pos_result);
      move(2, 1'b1);
      waitc(16'h0004, 20);
      chk("dir", 16'h0001, {15'h0000, pos_dir});
      jump <= 1'b1;
      @(posedge sys_clk);
      jump <= 1'b0;
      repeat (10) @(posedge sys_clk);
      chk("count", 16'h0004, pos_count);
      rdc("count", `COUNT_OFS, 16'h0004);
      rdc("result", `RESULT_OFS, 16'h3fff);
      wr(`CTRL_OFS, 32'h00000002);
      wr(`CTRL_OFS, 32'h00000007);
      move(4, 1'b0);
      chk("count", 16'h0000, pos_count);
      chk("result", 16'h0000, pos_result);
      // Armed, direction kept, track B high, track A low
      rdc("stat", `STAT_OFS, 16'h0016);
      idx_on <= 1'b1;
      repeat (5) @(posedge sys_clk);
      idx_on <= 1'b0;
      repeat (30) @(posedge sys_clk);
      chk("run", 16'h0000, {15'h0000, pos_running});
      idx_on <= 1'b1;
      for (n = 0; pos_running !== 1'b1 && n < 2000; n++) @(posedge sys_clk);
      chk("run", 16'h0001, {15'h0000, pos_running});
      idx_on <= 1'b0;
      move(3, 1'b0);
      waitc(16'h0003, 20);
      summarize();
   end
endmodule : encoder_input_conditioning_tb_top
